// >>> logic/pin_select_pkg.sv
// Purpose: constants for the remappable input selector block
// Assumes: 16-bit selector registers on a plain strobe port, 31 remappable pins
// Notes: register indices are word offsets on the local port
// What this block does
// - selector code all ones ties the peripheral input low
// - code 11110 selects remappable pin 30, the highest pin
// - codes below all ones select the pin whose index equals the code
// - pwm1 fault input follows selector in bits 4 down to 0
// - bits 15 down to 5 of single-selector registers read zero, ignore writes
// - reset loads ones into every selector bit, tying all inputs low
// - selectors read back the last written value or the reset value
package pin_select_pkg;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned SEL_W       = 5;
    localparam int unsigned PIN_COUNT   = 31;
    localparam int unsigned INPUT_COUNT = 5;

    localparam logic [ADDR_W-1:0] CAPTURE78_INPUT_SELECT_ADDR     = 4'h0;
    localparam logic [ADDR_W-1:0] COMPARE_FAULT_INPUT_SELECT_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] PWM1_FAULT_INPUT_SELECT_ADDR    = 4'h2;
    localparam logic [ADDR_W-1:0] PWM2_FAULT_INPUT_SELECT_ADDR    = 4'h3;

    localparam int unsigned LOW_SEL_LSB  = 0;
    localparam int unsigned HIGH_SEL_LSB = 8;

    localparam logic [SEL_W-1:0] SEL_TIED_LOW = 5'h1F;
    localparam logic [SEL_W-1:0] SEL_RESET    = 5'h1F;
endpackage

// >>> logic/pin_route.sv
`timescale 1ns/1ps
// Purpose: one registered pin multiplexer for a remapped peripheral input
// Assumes: pins synchronous to i_mclk
// Notes: output registered, so it lags the pin by one cycle
module pin_route
#(
    parameter int unsigned PINS = pin_select_pkg::PIN_COUNT
) (
    input  wire logic                             i_mclk,   // system clock
    input  wire logic                             i_reset,  // synchronous reset, high
    input  wire logic [pin_select_pkg::SEL_W-1:0] i_sel,    // selector code
    input  wire logic [PINS-1:0]                  i_pins,   // remappable pin levels
    output logic                                  o_level   // routed level
);
    import pin_select_pkg::*;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_level <= 1'b0;
        end else if (i_sel == SEL_TIED_LOW || 32'(i_sel) >= PINS) begin
            o_level <= 1'b0;
        end else begin
            o_level <= i_pins[i_sel];
        end
    end
endmodule

// >>> logic/remappable_input_select.sv
`timescale 1ns/1ps
// Purpose: input selector registers and routing for capture, compare fault, pwm faults
// Assumes: read data stands one cycle after the read strobe; unmapped reads return zero
// Notes: each routed input lags its pin by one clock
module remappable_input_select
#(
    parameter int unsigned PINS = pin_select_pkg::PIN_COUNT
) (
    input  wire logic                        i_mclk,            // system clock
    input  wire logic                        i_reset,           // synchronous reset, high
    input  wire logic [pin_select_pkg::ADDR_W-1:0] i_addr,      // register index
    input  wire logic [pin_select_pkg::DATA_W-1:0] i_wdata,     // write data
    input  wire logic                        i_wr,              // write strobe
    input  wire logic                        i_rd,              // read strobe
    input  wire logic [PINS-1:0]             i_remappable_pin_n,// pin levels
    output logic [pin_select_pkg::DATA_W-1:0] o_rdata,          // read data
    output logic                             o_capture7_input,  // to capture 7
    output logic                             o_capture8_input,  // to capture 8
    output logic                             o_compare_fault_input, // to compare fault
    output logic                             o_pwm1_fault_input,    // to pwm1 fault
    output logic                             o_pwm2_fault_input     // to pwm2 fault
);
    import pin_select_pkg::*;

    logic [SEL_W-1:0] capture7_pin_selector_q;
    logic [SEL_W-1:0] capture8_pin_selector_q;
    logic [SEL_W-1:0] compare_fault_pin_selector_q;
    logic [SEL_W-1:0] pwm1_fault_pin_selector_q;
    logic [SEL_W-1:0] pwm2_fault_pin_selector_q;
    logic [DATA_W-1:0] rdata_d;
    logic [INPUT_COUNT-1:0] routed;
    logic [SEL_W-1:0] sels [INPUT_COUNT];

    // upper field bits never stored, so they cannot read back
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            capture7_pin_selector_q      <= SEL_RESET;
            capture8_pin_selector_q      <= SEL_RESET;
            compare_fault_pin_selector_q <= SEL_RESET;
            pwm1_fault_pin_selector_q    <= SEL_RESET;
            pwm2_fault_pin_selector_q    <= SEL_RESET;
        end else if (i_wr) begin
            if (i_addr == CAPTURE78_INPUT_SELECT_ADDR) begin
                capture7_pin_selector_q <= i_wdata[LOW_SEL_LSB +: SEL_W];
                capture8_pin_selector_q <= i_wdata[HIGH_SEL_LSB +: SEL_W];
            end else if (i_addr == COMPARE_FAULT_INPUT_SELECT_ADDR) begin
                compare_fault_pin_selector_q <= i_wdata[LOW_SEL_LSB +: SEL_W];
            end else if (i_addr == PWM1_FAULT_INPUT_SELECT_ADDR) begin
                pwm1_fault_pin_selector_q <= i_wdata[LOW_SEL_LSB +: SEL_W];
            end else if (i_addr == PWM2_FAULT_INPUT_SELECT_ADDR) begin
                pwm2_fault_pin_selector_q <= i_wdata[LOW_SEL_LSB +: SEL_W];
            end
        end
    end

    always_comb begin
        rdata_d = '0;
        if (i_addr == CAPTURE78_INPUT_SELECT_ADDR) begin
            rdata_d[LOW_SEL_LSB +: SEL_W]  = capture7_pin_selector_q;
            rdata_d[HIGH_SEL_LSB +: SEL_W] = capture8_pin_selector_q;
        end else if (i_addr == COMPARE_FAULT_INPUT_SELECT_ADDR) begin
            rdata_d[LOW_SEL_LSB +: SEL_W] = compare_fault_pin_selector_q;
        end else if (i_addr == PWM1_FAULT_INPUT_SELECT_ADDR) begin
            rdata_d[LOW_SEL_LSB +: SEL_W] = pwm1_fault_pin_selector_q;
        end else if (i_addr == PWM2_FAULT_INPUT_SELECT_ADDR) begin
            rdata_d[LOW_SEL_LSB +: SEL_W] = pwm2_fault_pin_selector_q;
        end
    end

    // read data held only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= '0;
        end
    end

    assign sels[0] = capture7_pin_selector_q;
    assign sels[1] = capture8_pin_selector_q;
    assign sels[2] = compare_fault_pin_selector_q;
    assign sels[3] = pwm1_fault_pin_selector_q;
    assign sels[4] = pwm2_fault_pin_selector_q;

    for (genvar g = 0; g < INPUT_COUNT; g++) begin : g_route
        pin_route #(
            .PINS (PINS)
        ) u_route (
            .i_mclk  (i_mclk),
            .i_reset (i_reset),
            .i_sel   (sels[g]),
            .i_pins  (i_remappable_pin_n),
            .o_level (routed[g])
        );
    end

    // outputs straight from the route flops
    assign o_capture7_input      = routed[0];
    assign o_capture8_input      = routed[1];
    assign o_compare_fault_input = routed[2];
    assign o_pwm1_fault_input    = routed[3];
    assign o_pwm2_fault_input    = routed[4];

    property p_tied_low;
        @(posedge i_mclk) disable iff (i_reset)
        (pwm2_fault_pin_selector_q == SEL_TIED_LOW) |=> !o_pwm2_fault_input;
    endproperty
    a_tied_low: assert property (p_tied_low) else $error("tied-low input not low");

    property p_pin30;
        @(posedge i_mclk) disable iff (i_reset)
        (compare_fault_pin_selector_q == 5'h1E) |=>
            (o_compare_fault_input == $past(i_remappable_pin_n[30]));
    endproperty
    a_pin30: assert property (p_pin30) else $error("code 1E not routed to pin 30");

    property p_index;
        @(posedge i_mclk) disable iff (i_reset)
        (capture7_pin_selector_q != SEL_TIED_LOW) |=>
            (o_capture7_input == $past(i_remappable_pin_n[capture7_pin_selector_q]));
    endproperty
    a_index: assert property (p_index) else $error("capture7 routes wrong pin");

    property p_pwm1_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == PWM1_FAULT_INPUT_SELECT_ADDR) |=>
            (pwm1_fault_pin_selector_q == $past(i_wdata[4:0]));
    endproperty
    a_pwm1_write: assert property (p_pwm1_write) else $error("pwm1 selector not loaded");

    property p_upper_zero;
        @(posedge i_mclk) disable iff (i_reset)
        (i_rd && i_addr == PWM2_FAULT_INPUT_SELECT_ADDR) |=> (o_rdata[15:5] == 11'h000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unimplemented bits nonzero");

    // checked at the release edge only: before the first edge the selectors are still unknown
    property p_reset_ones;
        @(posedge i_mclk) (!i_reset && $past(i_reset)) |->
            (capture7_pin_selector_q == 5'h1F && capture8_pin_selector_q == 5'h1F &&
             compare_fault_pin_selector_q == 5'h1F &&
             pwm1_fault_pin_selector_q == 5'h1F && pwm2_fault_pin_selector_q == 5'h1F);
    endproperty
    a_reset_ones: assert property (p_reset_ones) else $error("selector not ones after reset");

    property p_readback;
        @(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == CAPTURE78_INPUT_SELECT_ADDR) ##1
            (i_rd && i_addr == CAPTURE78_INPUT_SELECT_ADDR && !i_wr) |=>
            (o_rdata == ($past(i_wdata, 2) & 16'h1F1F));
    endproperty
    a_readback: assert property (p_readback) else $error("readback differs from write");

    property p_capture8;
        @(posedge i_mclk) disable iff (i_reset)
        (capture8_pin_selector_q == 5'h00) |=> (o_capture8_input == $past(i_remappable_pin_n[0]));
    endproperty
    a_capture8: assert property (p_capture8) else $error("capture8 not following pin 0");

    property p_reset_outs;
        @(posedge i_mclk) (!i_reset && $past(i_reset)) |->
            (o_rdata == 16'h0000 && routed == 5'h00);
    endproperty
    a_reset_outs: assert property (p_reset_outs)
        else $error("outputs not low after reset");

    property p_rdata_idle;
        @(posedge i_mclk) disable iff (i_reset)
        !i_rd |=> (o_rdata == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

    property p_capture78_gaps;
        @(posedge i_mclk) disable iff (i_reset)
        (i_rd && i_addr == CAPTURE78_INPUT_SELECT_ADDR) |=>
            (o_rdata[15:13] == 3'h0 && o_rdata[7:5] == 3'h0);
    endproperty
    a_capture78_gaps: assert property (p_capture78_gaps)
        else $error("capture register gap bits nonzero");

    property p_single_upper_zero;
        @(posedge i_mclk) disable iff (i_reset)
        (i_rd && (i_addr == COMPARE_FAULT_INPUT_SELECT_ADDR ||
                  i_addr == PWM1_FAULT_INPUT_SELECT_ADDR)) |=> (o_rdata[15:5] == 11'h000);
    endproperty
    a_single_upper_zero: assert property (p_single_upper_zero)
        else $error("single selector upper bits nonzero");

    property p_capture_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == CAPTURE78_INPUT_SELECT_ADDR) |=>
            (capture7_pin_selector_q == $past(i_wdata[4:0]) &&
             capture8_pin_selector_q == $past(i_wdata[12:8]));
    endproperty
    a_capture_write: assert property (p_capture_write)
        else $error("capture selectors not loaded");

    property p_compare_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == COMPARE_FAULT_INPUT_SELECT_ADDR) |=>
            (compare_fault_pin_selector_q == $past(i_wdata[4:0]));
    endproperty
    a_compare_write: assert property (p_compare_write)
        else $error("compare selector not loaded");

    property p_pwm2_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == PWM2_FAULT_INPUT_SELECT_ADDR) |=>
            (pwm2_fault_pin_selector_q == $past(i_wdata[4:0]));
    endproperty
    a_pwm2_write: assert property (p_pwm2_write)
        else $error("pwm2 selector not loaded");

    // selectors may only move on a write; anything else would reroute an input silently
    property p_sel_hold;
        @(posedge i_mclk) disable iff (i_reset)
        !i_wr |=> ($stable(capture7_pin_selector_q) && $stable(capture8_pin_selector_q) &&
                   $stable(compare_fault_pin_selector_q) &&
                   $stable(pwm1_fault_pin_selector_q) && $stable(pwm2_fault_pin_selector_q));
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("selector changed without a write");

    property p_capture7_tied;
        @(posedge i_mclk) disable iff (i_reset)
        (capture7_pin_selector_q == SEL_TIED_LOW) |=> !o_capture7_input;
    endproperty
    a_capture7_tied: assert property (p_capture7_tied)
        else $error("capture7 not tied low");

    property p_capture8_tied;
        @(posedge i_mclk) disable iff (i_reset)
        (capture8_pin_selector_q == SEL_TIED_LOW) |=> !o_capture8_input;
    endproperty
    a_capture8_tied: assert property (p_capture8_tied)
        else $error("capture8 not tied low");

    property p_compare_tied;
        @(posedge i_mclk) disable iff (i_reset)
        (compare_fault_pin_selector_q == SEL_TIED_LOW) |=> !o_compare_fault_input;
    endproperty
    a_compare_tied: assert property (p_compare_tied)
        else $error("compare fault not tied low");

    property p_pwm1_index;
        @(posedge i_mclk) disable iff (i_reset)
        (pwm1_fault_pin_selector_q != SEL_TIED_LOW) |=>
            (o_pwm1_fault_input == $past(i_remappable_pin_n[pwm1_fault_pin_selector_q]));
    endproperty
    a_pwm1_index: assert property (p_pwm1_index)
        else $error("pwm1 fault routes wrong pin");

    property p_pwm2_index;
        @(posedge i_mclk) disable iff (i_reset)
        (pwm2_fault_pin_selector_q != SEL_TIED_LOW) |=>
            (o_pwm2_fault_input == $past(i_remappable_pin_n[pwm2_fault_pin_selector_q]));
    endproperty
    a_pwm2_index: assert property (p_pwm2_index)
        else $error("pwm2 fault routes wrong pin");

    property p_compare_index;
        @(posedge i_mclk) disable iff (i_reset)
        (compare_fault_pin_selector_q != SEL_TIED_LOW) |=>
            (o_compare_fault_input == $past(i_remappable_pin_n[compare_fault_pin_selector_q]));
    endproperty
    a_compare_index: assert property (p_compare_index)
        else $error("compare fault routes wrong pin");
endmodule

// >>> bench/pin_drive_model.sv
// Purpose: stands in for the remappable pins feeding the selector block
// Assumes: pins change just after the rising clock edge, as synchronous inputs
// Notes: levels are always driven; no pin is ever left floating
`timescale 1ns/1ps
module pin_drive_model (
    input  wire logic        i_mclk,  // system clock
    input  wire logic [30:0] i_level, // requested pin levels
    output logic      [30:0] o_pins   // levels on the pins
);
    always_ff @(posedge i_mclk) begin
        o_pins <= i_level;
    end
endmodule

// >>> bench/remappable_input_select_tb.sv
// Purpose: self-checking bench for the remappable input selector
// Assumes: one-cycle routing lag and read data one cycle after the strobe
// Notes: outputs are packed capture7, capture8, compare, pwm1, pwm2
`timescale 1ns/1ps
module remappable_input_select_tb;
    import pin_select_pkg::*;
    logic        i_mclk  = 1'b0;
    logic        i_reset = 1'b1;
    logic [3:0]  i_addr  = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic [30:0] lvl     = 31'h7FFFFFFF;
    logic [30:0] pins;
    logic [15:0] o_rdata;
    wire  [4:0]  outs;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #2.5 i_mclk = ~i_mclk;

    pin_drive_model u_pins (.i_mclk(i_mclk), .i_level(lvl), .o_pins(pins));
    remappable_input_select u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_remappable_pin_n(pins),
        .o_rdata(o_rdata), .o_capture7_input(outs[4]), .o_capture8_input(outs[3]),
        .o_compare_fault_input(outs[2]), .o_pwm1_fault_input(outs[1]),
        .o_pwm2_fault_input(outs[0]));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
        @(posedge i_mclk) i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_mclk) begin i_rd <= 1'b1; i_addr <= a; end
        @(posedge i_mclk) i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, exp);
    endtask

    // write and read with no gap, so the read sees the freshly written selectors
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(posedge i_mclk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
        @(posedge i_mclk) begin i_wr <= 1'b0; i_rd <= 1'b1; end
        @(posedge i_mclk) i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, exp);
    endtask

    // routed outputs need one edge in the model and one in the selector
    task automatic route(input logic [30:0] v, input logic [4:0] exp);
        @(posedge i_mclk) lvl <= v;
        repeat (3) @(posedge i_mclk);
        #1 chk("routed", {11'h000, outs}, {11'h000, exp});
    endtask

    task automatic t_reset();
        rd(4'h0, 16'h1F1F);
        rd(4'h1, 16'h001F);
        rd(4'h2, 16'h001F);
        rd(4'h3, 16'h001F);
        route(31'h7FFFFFFF, 5'b00000);
    endtask

    task automatic t_capture();
        wr(4'h0, 16'hFEE0);
        rd(4'h0, 16'h1E00);
        route(31'h00000001, 5'b10000);
        route(31'h40000000, 5'b01000);
    endtask

    task automatic t_faults();
        wr(4'h1, 16'hFFE1);
        wr(4'h2, 16'h0003);
        wr(4'h3, 16'h001E);
        rd(4'h1, 16'h0001);
        rd(4'h2, 16'h0003);
        route(31'h00000008, 5'b00010);
        route(31'h00000002, 5'b00100);
        route(31'h40000000, 5'b01001);
        wr(4'h3, 16'h001F);
        route(31'h7FFFFFFF, 5'b11110);
        wr(4'h1, 16'h001E);
        route(31'h40000000, 5'b01100);
        wr_rd(4'h0, 16'hE0E2, 16'h0002);
        route(31'h00000005, 5'b11000);
        rd(4'h7, 16'h0000);
    endtask

    // reset in mid-run must bring every selector back to tied low
    task automatic t_rerun();
        @(posedge i_mclk) i_reset <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_reset();
    endtask

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_reset();
        t_capture();
        t_faults();
        t_rerun();
        give_verdict();
    end
endmodule
